// *** pkg/lio_consts.vh ***
`ifndef LIO_CONSTS_VH
`define LIO_CONSTS_VH
// ==========================================================
// Register offsets (byte addresses)
`define LIO_OFF_IN_STATE   8'h00
`define LIO_OFF_IN_SET     8'h04
`define LIO_OFF_IN_CLR     8'h08
`define LIO_OFF_IN_MODE    8'h0c
`define LIO_OFF_OUT_STATE  8'h10
`define LIO_OFF_EV_EN      8'h14
`define LIO_OFF_IRQ_STAT   8'h18
`define LIO_OFF_IRQ_MASK   8'h1c
`define LIO_OFF_EV_DATA    8'h20
`define LIO_OFF_EV_STAMP   8'h24
`define LIO_OFF_EV_POP     8'h28
`define LIO_OFF_OFFDLY     8'h2c
`define LIO_OFF_TIME       8'h30
// ==========================================================
// Event enable fields
`define LIO_EN_OUT_ON      0
`define LIO_EN_OUT_OFF     1
`define LIO_EN_IN_ON       2
`define LIO_EN_IN_OFF      3
`define LIO_EV_EN_RST      4'hf
// ==========================================================
// Interrupt status fields
`define LIO_IRQ_EVENT      0
`define LIO_IRQ_OVFL       1
`define LIO_IRQ_PULSE_END  2
// ==========================================================
// Event record fields
`define LIO_REC_GROUP      6
`define LIO_REC_EDGE       5
`define LIO_GRP_OUT        1'b0
`define LIO_GRP_IN         1'b1
// ==========================================================
// Timing
`define LIO_CLK_HZ         50000000
`define LIO_TICK_NS        1000000
`define LIO_TICK_CYC       ((`LIO_CLK_HZ / 1000) * (`LIO_TICK_NS / 1000000))
`define LIO_PULSE_MS       5
`define LIO_OFFDLY_RST     16'h0000
`endif

// *** src/lio_core.v ***
// How it works
// RL1: Thirty-two output bits are driven from the user logic inputs.
// RL2: Each output bit is offered on a registered port for blocking, groups, relays and LEDs.
// RL3: The present output state can be read by software for remote reporting.
// RL4: Thirty-two input bits are commanded to one or zero by software acting for the operator.
// RL5: All input bits clear to zero under reset, whatever their mode.
// RL6: In hold mode a one command sets a bit that stays until a zero command or reset.
// RL7: In pulse mode a one command sets a bit that clears itself after 5 ms.
// RL8: A pulse input can be stretched by an off-delay onto an output, held for the added delay.
// RL9: Rising changes give ON events and falling changes OFF events, outputs and inputs grouped apart.
// RL10: Separate enables per group decide whether ON, OFF or both events are stored.
// RL11: Each stored event carries the millisecond time stamp of the change.
// RL12: Pulses are timed with a free-running millisecond tick, a new one command restarts them.
//
// Added by the designer: the strobed register port and the placing of the registers.
`include "lio_consts.vh"
module lio_core #(
   parameter N      = 32,
   parameter EV_AW  = 4,
   parameter TICK   = `LIO_TICK_CYC,
   parameter PULSE  = `LIO_PULSE_MS
) (
   // Clock and reset
   input  wire          sys_clk,
   input  wire          rst_b,
   // Register port
   input  wire [7:0]    reg_addr,
   input  wire [31:0]   reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [31:0]   reg_rdata,
   // User logic side
   input  wire [N-1:0]  user_out,
   input  wire [4:0]    stretch_sel,
   output reg  [N-1:0]  logic_out,
   output reg  [N-1:0]  logic_in,
   // Interrupt
   output reg           irq
);
   localparam RW = 7 + 32; // record: group, edge, index, stamp
   localparam ST_IDLE = 2'b01;
   localparam ST_SCAN = 2'b10;

   reg [N-1:0]     in_r, in_nxt, mode_r, out_r, out_nxt;
   reg [N-1:0]     in_prev_r, out_prev_r, in_chg_r, out_chg_r, in_chg_nxt, out_chg_nxt;
   reg [3:0]       ev_en_r;
   reg [2:0]       stat_r, mask_r;
   reg [15:0]      offdly_r, stretch_cnt_r;
   reg [31:0]      ms_r, tick_cnt_r;
   reg             tick_r;
   reg [3:0]       pcnt_r [0:N-1];
   reg [N-1:0]     pend_in_r, pend_out_r;
   reg [1:0]       st_r;
   reg [EV_AW-1:0] wp_r, rp_r;
   reg [EV_AW:0]   cnt_r;
   reg             wr_en;
   reg [RW-1:0]    wr_rec;
   reg             pulse_end;
   reg [5:0]       pick;
   reg             head_ok_r;
   wire [RW-1:0]   rd_rec;
   integer         i;

   // Decoded set and clear strobes, visible to the combinational logic
   wire            in_set_w  = reg_wr && (reg_addr == `LIO_OFF_IN_SET);
   wire            in_clr_w  = reg_wr && (reg_addr == `LIO_OFF_IN_CLR);
   // Buffer push and pop strobes
   wire            ev_push_w = wr_en && !cnt_r[EV_AW];
   wire            ev_pop_w  = reg_wr && (reg_addr == `LIO_OFF_EV_POP) && (cnt_r != 0);

   // Lowest set bit of a vector, 6'h3f when none
   function [5:0] first_set;
      input [N-1:0] v;
      integer k;
      begin
         first_set = 6'h3f;
         for (k = N-1; k >= 0; k = k - 1) begin
            if (v[k]) begin
               first_set = k[5:0];
            end
         end
      end
   endfunction

   // Register write decode
   function hit;
      input [7:0] off;
      begin
         hit = reg_wr && (reg_addr == off);
      end
   endfunction

   // ==========================================================
   // Millisecond tick and time stamp counter
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b0;
         ms_r       <= 32'h0;
      end else begin
         tick_r <= (tick_cnt_r == TICK - 1); // RL12
         if (tick_cnt_r == TICK - 1) begin
            tick_cnt_r <= 32'h0;
         end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
         end
         if (tick_r) begin
            ms_r <= ms_r + 32'h1; // RL11
         end
      end
   end

   // ==========================================================
   // Input commands, hold and pulse behaviour
   always @* begin
      in_nxt    = in_r;
      pulse_end = 1'b0;
      for (i = 0; i < N; i = i + 1) begin
         if (mode_r[i] && in_r[i] && tick_r && pcnt_r[i] == 4'h1) begin
            in_nxt[i] = 1'b0; // RL7
            pulse_end = 1'b1;
         end
         if (in_clr_w && reg_wdata[i]) begin
            in_nxt[i] = 1'b0; // RL6
         end
         if (in_set_w && reg_wdata[i]) begin
            in_nxt[i] = 1'b1; // RL4
         end
      end
   end

   // Input state and pulse counters
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         in_r   <= {N{1'b0}}; // RL5
         mode_r <= {N{1'b0}};
         for (i = 0; i < N; i = i + 1) begin
            pcnt_r[i] <= 4'h0;
         end
      end else begin
         in_r <= in_nxt;
         if (hit(`LIO_OFF_IN_MODE)) begin
            mode_r <= reg_wdata[N-1:0];
         end
         for (i = 0; i < N; i = i + 1) begin
            // Extra tick covers the partial first millisecond
            if (hit(`LIO_OFF_IN_SET) && reg_wdata[i]) begin
               pcnt_r[i] <= PULSE[3:0] + 4'h1; // RL12
            end else if (tick_r && pcnt_r[i] != 4'h0) begin
               pcnt_r[i] <= pcnt_r[i] - 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Outputs with off-delay stretch on one selected bit
   always @* begin
      out_nxt = user_out; // RL1
      if (stretch_cnt_r != 16'h0) begin
         out_nxt[stretch_sel] = 1'b1; // RL8
      end
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_r         <= {N{1'b0}};
         offdly_r      <= `LIO_OFFDLY_RST;
         stretch_cnt_r <= 16'h0;
      end else begin
         out_r <= out_nxt;
         if (hit(`LIO_OFF_OFFDLY)) begin
            offdly_r <= reg_wdata[15:0];
         end
         if (user_out[stretch_sel]) begin
            stretch_cnt_r <= offdly_r; // RL8
         end else if (tick_r && stretch_cnt_r != 16'h0) begin
            stretch_cnt_r <= stretch_cnt_r - 16'h1;
         end
      end
   end

   // ==========================================================
   // Change detection and event scan
   always @* begin
      in_chg_nxt  = pend_in_r | ((in_r ^ in_prev_r) &
                    ((in_r & {N{ev_en_r[`LIO_EN_IN_ON]}}) |
                     (~in_r & {N{ev_en_r[`LIO_EN_IN_OFF]}}))); // RL10
      out_chg_nxt = pend_out_r | ((out_r ^ out_prev_r) &
                    ((out_r & {N{ev_en_r[`LIO_EN_OUT_ON]}}) |
                     (~out_r & {N{ev_en_r[`LIO_EN_OUT_OFF]}})));
      wr_en  = 1'b0;
      wr_rec = {RW{1'b0}};
      pick   = first_set(out_chg_nxt);
      if (pick != 6'h3f) begin
         wr_en  = 1'b1; // RL9
         wr_rec = {`LIO_GRP_OUT, out_r[pick[4:0]], pick[4:0], ms_r}; // RL11
      end else begin
         pick = first_set(in_chg_nxt);
         if (pick != 6'h3f) begin
            wr_en  = 1'b1; // RL9
            wr_rec = {`LIO_GRP_IN, in_r[pick[4:0]], pick[4:0], ms_r};
         end
      end
   end

   // Pending change sets, scanned one per cycle
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         in_prev_r  <= {N{1'b0}};
         out_prev_r <= {N{1'b0}};
         pend_in_r  <= {N{1'b0}};
         pend_out_r <= {N{1'b0}};
         st_r       <= ST_IDLE;
      end else begin
         in_prev_r  <= in_r;
         out_prev_r <= out_r;
         pend_in_r  <= in_chg_nxt;
         pend_out_r <= out_chg_nxt;
         if (wr_en && out_chg_nxt != {N{1'b0}}) begin
            pend_out_r[pick[4:0]] <= 1'b0;
         end else if (wr_en) begin
            pend_in_r[pick[4:0]] <= 1'b0;
         end
         case (st_r)
            ST_IDLE: st_r <= wr_en ? ST_SCAN : ST_IDLE;
            ST_SCAN: st_r <= wr_en ? ST_SCAN : ST_IDLE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Event buffer pointers, overwrite refused when full
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_r      <= {EV_AW{1'b0}};
         rp_r      <= {EV_AW{1'b0}};
         cnt_r     <= {(EV_AW+1){1'b0}};
         head_ok_r <= 1'b0;
      end else begin
         if (ev_push_w) begin
            wp_r <= wp_r + 1'b1;
         end
         if (ev_pop_w) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + {{EV_AW{1'b0}}, ev_push_w} - {{EV_AW{1'b0}}, ev_pop_w};
         // Head shown only once the registered memory read has caught up
         head_ok_r <= (cnt_r != 0) && !ev_pop_w;
      end
   end

   lio_evmem #(
      .DW (RW),
      .AW (EV_AW)
   ) u_evmem (
      .sys_clk (sys_clk),
      .wr_en   (ev_push_w),
      .wr_addr (wp_r),
      .wr_data (wr_rec),
      .rd_addr (rp_r),
      .rd_data (rd_rec)
   );

   // ==========================================================
   // Interrupt status, mask, enables, read data, outputs
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_r    <= 3'h0;
         mask_r    <= 3'h0;
         ev_en_r   <= `LIO_EV_EN_RST;
         reg_rdata <= 32'h0;
         irq       <= 1'b0;
         logic_out <= {N{1'b0}};
         logic_in  <= {N{1'b0}};
      end else begin
         // Set wins over write-one-to-clear
         stat_r <= (stat_r & ~({3{hit(`LIO_OFF_IRQ_STAT)}} & reg_wdata[2:0]))
                 | {pulse_end, wr_en && cnt_r[EV_AW], wr_en};
         if (hit(`LIO_OFF_IRQ_MASK)) begin
            mask_r <= reg_wdata[2:0];
         end
         if (hit(`LIO_OFF_EV_EN)) begin
            ev_en_r <= reg_wdata[3:0]; // RL10
         end
         irq       <= |(stat_r & mask_r);
         logic_out <= out_r; // RL2
         logic_in  <= in_r;
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `LIO_OFF_IN_STATE:  reg_rdata <= in_r;
               `LIO_OFF_IN_MODE:   reg_rdata <= mode_r;
               `LIO_OFF_OUT_STATE: reg_rdata <= out_r; // RL3
               `LIO_OFF_EV_EN:     reg_rdata <= {28'h0, ev_en_r};
               `LIO_OFF_IRQ_STAT:  reg_rdata <= {29'h0, stat_r};
               `LIO_OFF_IRQ_MASK:  reg_rdata <= {29'h0, mask_r};
               `LIO_OFF_EV_DATA:   reg_rdata <= {head_ok_r, 18'h0, cnt_r[EV_AW:0] == 0 ?
                                                 5'h0 : cnt_r[4:0] , 1'b0, rd_rec[38:32]};
               `LIO_OFF_EV_STAMP:  reg_rdata <= rd_rec[31:0];
               `LIO_OFF_OFFDLY:    reg_rdata <= {16'h0, offdly_r};
               `LIO_OFF_TIME:      reg_rdata <= ms_r;
               default:            reg_rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule // lio_core

// *** src/lio_evmem.v ***
// ==========================================================
// Event record memory, registered read data
module lio_evmem #(
   parameter DW = 39,
   parameter AW = 4
) (
   // Clock
   input  wire          sys_clk,
   // Write port
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   // Read port
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Write and registered read
   always @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // lio_evmem

// *** testbench/lio_core_props.sv ***
`include "lio_consts.vh"
// ====
// Port checker
module lio_core_props (
   // Clock and reset
   input logic        sys_clk,
   input logic        rst_b,
   // Register port
   input logic [7:0]  reg_addr,
   input logic [31:0] reg_wdata,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [31:0] reg_rdata,
   // User side
   input logic [31:0] user_out,
   input logic [4:0]  stretch_sel,
   input logic [31:0] logic_out,
   input logic [31:0] logic_in,
   input logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic s_w;
   logic c_w;
   // Set and clear writes
   assign s_w = reg_wr && reg_addr == `LIO_OFF_IN_SET;
   assign c_w = reg_wr && reg_addr == `LIO_OFF_IN_CLR;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Register port
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h30 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   // Outputs
   a_out_delay: assert property (((logic_out ^ $past(user_out, 2))
      & ~(32'h1 << stretch_sel)) == 32'h0)
      else $error("output does not follow user logic");
   a_out_stretch: assert property ($fell(logic_out[stretch_sel])
      |-> !$past(user_out[stretch_sel], 2))
      else $error("stretched output fell early");
   // Inputs
   a_in_reset: assert property ($rose(rst_b) |-> logic_in == 0 && logic_out == 0 && !irq)
      else $error("outputs not clear after reset");
   a_in_rise: assert property (|(logic_in & ~$past(logic_in)) |-> $past(s_w, 2))
      else $error("input rose without set");
   a_set_shows: assert property (s_w ##1 !c_w |-> ##1
      (logic_in & $past(reg_wdata, 2)) == $past(reg_wdata, 2))
      else $error("set not applied");
   a_clr_shows: assert property (c_w ##1 !s_w |-> ##1
      (logic_in & $past(reg_wdata, 2)) == 32'h0)
      else $error("clear not applied");
   // Main scenarios
   c_set: cover property (s_w);
   c_fall: cover property ($fell(logic_in[0]));
   c_irq: cover property ($rose(irq));
endmodule // lio_core_props

bind lio_core lio_core_props u_lio_core_props (.sys_clk, .rst_b, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .user_out, .stretch_sel, .logic_out, .logic_in, .irq);

// *** testbench/lio_core_tb.sv ***
`include "lio_consts.vh"
// ====
// Bench top
module lio_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam TK = 10;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata, user_out, logic_out, logic_in, d, t0;
   logic [30:0] pattern = 31'h0;
   logic [4:0]  stretch_sel = 5'h1f;
   logic        irq;
   int          miscompares = 0, n_checks = 0, cyc = 0, n;
   // Clock
   always #10 sys_clk = ~sys_clk;
   lio_core #(.TICK(TK)) u_lio_core (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .user_out, .stretch_sel, .logic_out, .logic_in, .irq);
   lio_user_model u_lio_user_model (.sys_clk, .pattern, .logic_in, .user_out);
   // ====
   // Helpers
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
      cmp(v, ($isunknown(v) || v < lo) ? lo : (v > hi) ? hi : v);
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a, d);
      cmp(d, e);
   endtask
   // ====
   // Scenarios
   task automatic t_reset;
      cmp(logic_in, 32'h0);
      rdc(`LIO_OFF_IN_MODE, 32'h0);
      rdc(`LIO_OFF_EV_EN, 32'hf);
      rdc(`LIO_OFF_IRQ_MASK, 32'h0);
      rdc(8'h3c, 32'h0);
   endtask
   task automatic t_hold;
      wr(`LIO_OFF_IN_SET, 32'h0000_0f00);
      settle(8 * TK);
      rdc(`LIO_OFF_IN_STATE, 32'h0000_0f00);
      wr(`LIO_OFF_IN_CLR, 32'h0000_0100);
      rdc(`LIO_OFF_IN_STATE, 32'h0000_0e00);
      cmp(logic_in, 32'h0000_0e00);
      wr(`LIO_OFF_IN_CLR, 32'hffff_ffff);
      @(posedge sys_clk) pattern <= 31'h1234_5678;
      settle(4);
      cmp(logic_out, 32'h1234_5678);
      rdc(`LIO_OFF_OUT_STATE, 32'h1234_5678);
      @(posedge sys_clk) pattern <= 31'h0;
   endtask
   task automatic t_pulse;
      wr(`LIO_OFF_OFFDLY, 32'h3);
      wr(`LIO_OFF_IN_MODE, 32'h1);
      rdc(`LIO_OFF_IN_MODE, 32'h1);
      wr(`LIO_OFF_IN_SET, 32'h1);
      settle(2 * TK);
      cmp(32'(logic_in[0]), 32'h1);
      wr(`LIO_OFF_IN_SET, 32'h1);
      for (n = 0; logic_in[0] === 1'b1 && n < 100; n++) settle(1);
      cmp_rng(n, `LIO_PULSE_MS * TK - 2, (`LIO_PULSE_MS + 1) * TK + 3);
      for (n = 0; logic_out[31] === 1'b1 && n < 100; n++) settle(1);
      cmp_rng(n, 2 * TK, 4 * TK + 4);
      wr(`LIO_OFF_IN_MODE, 32'h0);
   endtask
   task automatic t_events;
      wr(`LIO_OFF_EV_EN, 32'h0);
      n = 0;
      do begin
         rd(`LIO_OFF_EV_DATA, d);
         wr(`LIO_OFF_EV_POP, 32'h0);
         settle(2);
         n++;
      end while (d[31] === 1'b1 && n < 40);
      wr(`LIO_OFF_EV_EN, 32'h4);
      rd(`LIO_OFF_TIME, t0);
      wr(`LIO_OFF_IN_SET, 32'h8);
      wr(`LIO_OFF_IN_CLR, 32'h8);
      settle(4);
      rd(`LIO_OFF_EV_DATA, d);
      cmp(d & 32'h8000_007f, 32'h8000_0063);
      rd(`LIO_OFF_EV_STAMP, d);
      cmp_rng(d, t0, t0 + 32'h1);
      wr(`LIO_OFF_EV_POP, 32'h0);
      settle(2);
      rd(`LIO_OFF_EV_DATA, d);
      cmp(32'(d[31]), 32'h0);
      wr(`LIO_OFF_EV_EN, 32'h2);
      @(posedge sys_clk) pattern <= 31'h20;
      settle(4);
      @(posedge sys_clk) pattern <= 31'h0;
      settle(6);
      rd(`LIO_OFF_EV_DATA, d);
      cmp(d & 32'h8000_007f, 32'h8000_0005);
      wr(`LIO_OFF_EV_POP, 32'h0);
   endtask
   task automatic t_irq;
      settle(2);
      cmp(32'(irq), 32'h0);
      wr(`LIO_OFF_IRQ_MASK, 32'h1);
      settle(2);
      cmp(32'(irq), 32'h1);
      rdc(`LIO_OFF_IRQ_STAT, 32'h7);
      wr(`LIO_OFF_IRQ_STAT, 32'h7);
      settle(2);
      cmp(32'(irq), 32'h0);
      rdc(`LIO_OFF_IRQ_STAT, 32'h0);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset;
      t_hold;
      t_pulse;
      t_events;
      t_irq;
      end_of_test;
   end
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_of_test;
      end
   end
endmodule // lio_core_tb

// *** testbench/lio_user_model.sv ***
// ====
// User logic model
module lio_user_model (
   // Clock
   input  logic        sys_clk,
   // Stimulus and feedback
   input  logic [30:0] pattern,
   input  logic [31:0] logic_in,
   output logic [31:0] user_out = 32'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pulse input 0 feeds output 31
   always @(posedge sys_clk) user_out <= {logic_in[0], pattern};
endmodule // lio_user_model
